// [src/qrw_pkg.sv]
// shared constants and types for the quad read, wrap and erase command logic
package qrw_pkg;
  localparam int ADDR_W = 24;
  localparam int CNT_W = 7;
  localparam int CLK_SYS_MHZ = 250;

  // opcodes
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_QUAD_READ_FOUR_DUMMY = 8'hE7;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_BURST_LEN = 8'hC0;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;

  // frame phase lengths in serial clocks
  localparam logic [6:0] CMD_CYC_SINGLE = 7'h08;
  localparam logic [6:0] CMD_CYC_QUAD = 7'h02;
  localparam logic [6:0] RD_ADDR_CYC = 7'h06;
  localparam logic [6:0] MODE_CYC = 7'h02;
  localparam logic [6:0] DUMMY_CYC_LONG = 7'h04;
  localparam logic [6:0] DUMMY_CYC_SHORT = 7'h02;
  localparam logic [6:0] ER_ADDR_CYC_SINGLE = 7'h18;
  localparam logic [6:0] ER_ADDR_CYC_QUAD = 7'h06;
  localparam logic [6:0] FF_CYC_SINGLE = 7'h08;
  localparam logic [6:0] FF_CYC_QUAD = 7'h02;
  localparam logic [6:0] CNT_MAX = 7'h7F;

  // burst length data byte
  localparam logic [3:0] WRAP_ON_NIB = 4'h0;
  localparam logic [3:0] WRAP_OFF_NIB = 4'h1;
  localparam int WRAP_MIN_LSB = 3;

  // status bits
  localparam int STAT_WIP_BIT = 0;
  localparam int STAT_WEL_BIT = 1;

  // erase geometry
  localparam int SECTOR_LSB = 12;
  localparam int HALF_BLOCK_LSB = 15;
  localparam int BLOCK_LSB = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_RECOVER = 2'b10
  } qrw_state_t;
endpackage : qrw_pkg

// [src/qrw_sync.sv]
// two flip-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
module qrw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : qrw_sync

// [src/qrw_flash_seq.sv]
// serial flash quad read, burst wrap, continuous read and erase command logic
// Functional notes
// - address sampled on rising edge, data nibbles driven on falling edge, four lines.
// - read address advances per byte and rolls over past highest address.
// - quad read is opcode, 6 address, 2 mode, 4 dummy, then data.
// - toggling mode byte keeps continuous read; next frame omits the opcode.
// - non-toggling mode byte leaves continuous read after the frame ends.
// - in continuous read, first clocks of a frame are address cycles.
// - continuous read only for the listed quad opcodes, never dual reads.
// - quad read refused while an erase runs, erase left undisturbed.
// - burst command C0h plus byte; upper nibble 0h enables, 1h disables wrap.
// - lower nibble selects wrap depth 8, 16, 32 or 64 bytes.
// - wrap keeps reads in an aligned unit inside the page.
// - wrap off after reset; kept until changed or reset.
// - wrap applies to the listed read opcodes only.
// - all-ones for 8 clocks (or quad 2) ends continuous read.
// - opcodes take 8 single-line clocks or 2 quad clocks; upper lines ignored.
// - sector erase clears the 4K sector chosen by address top bits to 12.
// - half block erase clears the 32K block holding the address.
// - erase ending off the last address bit boundary is dropped.
// - erase starts at chip select rise; busy 1 then 0, latch cleared at end.
// - erase of a protected region is not carried out.
// - status bit 0 is busy, bit 1 is write enable latch.
`timescale 1ns/1ps
module qrw_flash_seq #(
  parameter int ADDR_W = qrw_pkg::ADDR_W,
  parameter int SECTOR_ERASE_TIME_US = 100,
  parameter int HALF_BLOCK_ERASE_TIME_US = 400,
  parameter int ERASE_RECOVERY_TIME_US = 20
) (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic [3:0] DQ_I,
  output logic [3:0] DQ_O,
  output logic [3:0] DQ_OE_O,
  input wire logic HW_RESET_N_I,
  input wire logic QUAD_ENABLE_I,
  input wire logic QUAD_MODE_I,
  input wire logic [3:0] PROTECT_I,
  output logic [ADDR_W-1:0] ARRAY_ADDR_O,
  input wire logic [7:0] ARRAY_DATA_I,
  output logic ERASE_START_O,
  output logic ERASE_HALF_BLOCK_O,
  output logic [ADDR_W-1:0] ERASE_ADDR_O,
  output logic ERASE_ABORT_O,
  output logic [1:0] STATUS_O,
  output logic CONT_MODE_O,
  output logic WRAP_EN_O,
  output logic [1:0] WRAP_DEPTH_O
);
  localparam int SE_CYC = SECTOR_ERASE_TIME_US * qrw_pkg::CLK_SYS_MHZ;
  localparam int HBE_CYC = HALF_BLOCK_ERASE_TIME_US * qrw_pkg::CLK_SYS_MHZ;
  localparam int REC_CYC = ERASE_RECOVERY_TIME_US * qrw_pkg::CLK_SYS_MHZ;
  localparam int BLK_W = ADDR_W - qrw_pkg::BLOCK_LSB;

  // system-side configuration, read by the link side while chip select is low
  logic cont_r;
  logic [7:0] cont_op_r;
  logic qmode_r;
  logic qe_r;
  logic wrap_en_r;
  logic [1:0] wrap_depth_r;
  logic wip_r;
  logic wel_r;

  // ------------------------------------------------------------------
  // link domain, clocked by the host serial clock
  // ------------------------------------------------------------------
  logic in_frame_r;
  logic [6:0] cnt_r;
  logic [7:0] op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0] byte_r;
  logic ones_r;
  logic mode_ok_r;
  logic data_act_r;
  logic hi_r;
  logic busy_s;

  // erase end can land mid frame, so busy crosses through two flops
  qrw_sync #(.W(1), .RST_VAL(1'b0)) u_busy_sync (
    .clk_i(SCLK_I),
    .rst_n_i(1'b1),
    .d_i(wip_r),
    .q_o(busy_s)
  );

  wire first = ~in_frame_r;
  wire [6:0] cyc = first ? 7'h01 : ((cnt_r == qrw_pkg::CNT_MAX) ? cnt_r : cnt_r + 7'h01);
  // no opcode phase while continuous read is active
  wire [6:0] c_cmd = cont_r ? 7'h00 :
                     (qmode_r ? qrw_pkg::CMD_CYC_QUAD : qrw_pkg::CMD_CYC_SINGLE);
  wire [7:0] op_cur = first ? (cont_r ? cont_op_r : 8'h00) : op_r;
  wire in_cmd = (cyc <= c_cmd);
  // quad mode takes a nibble per clock, single-line mode only line 0
  wire [7:0] op_shift = qmode_r ? {op_cur[3:0], DQ_I} : {op_cur[6:0], DQ_I[0]};
  wire [7:0] op_nxt = in_cmd ? op_shift : op_cur;

  wire op_eb = (op_cur == qrw_pkg::OP_QUAD_IO_READ);
  wire op_e7 = (op_cur == qrw_pkg::OP_QUAD_READ_FOUR_DUMMY);
  wire op_0b = (op_cur == qrw_pkg::OP_FAST_READ);
  wire rd_op = qmode_r ? (op_eb | op_0b) : (op_eb | op_e7);
  wire rd_ok = rd_op & ~busy_s & (qmode_r | qe_r);
  wire [6:0] dum = op_e7 ? qrw_pkg::DUMMY_CYC_SHORT : qrw_pkg::DUMMY_CYC_LONG;
  wire [6:0] a_end = c_cmd + qrw_pkg::RD_ADDR_CYC;
  wire [6:0] m_end = a_end + qrw_pkg::MODE_CYC;
  wire [6:0] d_end = m_end + dum;

  wire er_op = (op_cur == qrw_pkg::OP_SECTOR_ERASE) | (op_cur == qrw_pkg::OP_HALF_BLOCK_ERASE);
  wire [6:0] er_len = qmode_r ? qrw_pkg::ER_ADDR_CYC_QUAD : qrw_pkg::ER_ADDR_CYC_SINGLE;
  wire [6:0] er_end = c_cmd + er_len;
  wire bl_op = (op_cur == qrw_pkg::OP_BURST_LEN) & ~cont_r;

  wire rd_addr_ph = rd_op & (cyc > c_cmd) & (cyc <= a_end);
  wire er_addr_ph = er_op & ~cont_r & (cyc > c_cmd) & (cyc <= er_end);
  wire mode_ph = rd_op & (cyc > a_end) & (cyc <= m_end);
  wire bl_ph = bl_op & (cyc > c_cmd) & (cyc <= c_cmd + c_cmd);

  // wrap keeps the upper address bits and counts only inside the unit
  wire [ADDR_W-1:0] wrap_mask = ~({ADDR_W{1'b1}} << (qrw_pkg::WRAP_MIN_LSB + wrap_depth_r));
  wire [ADDR_W-1:0] addr_plus = addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire [ADDR_W-1:0] addr_wrap = (addr_r & ~wrap_mask) | (addr_plus & wrap_mask);
  wire [ADDR_W-1:0] addr_inc = wrap_en_r ? addr_wrap : addr_plus;
  wire [ADDR_W-1:0] addr_nib = {addr_r[ADDR_W-5:0], DQ_I};
  wire [ADDR_W-1:0] addr_bit = {addr_r[ADDR_W-2:0], DQ_I[0]};
  wire advance = data_act_r & ~hi_r;
  wire [ADDR_W-1:0] addr_nxt = rd_addr_ph ? addr_nib :
                               er_addr_ph ? (qmode_r ? addr_nib : addr_bit) :
                               advance ? addr_inc : addr_r;

  wire [7:0] byte_cur = first ? 8'h00 : byte_r;
  wire [7:0] byte_nxt = mode_ph ? {byte_cur[3:0], DQ_I} :
                        bl_ph ? (qmode_r ? {byte_cur[3:0], DQ_I} : {byte_cur[6:0], DQ_I[0]}) :
                        byte_cur;
  wire line_ones = qmode_r ? (&DQ_I) : DQ_I[0];
  wire ones_nxt = (first | ones_r) & line_ones;
  wire mode_ok_nxt = (~first & mode_ok_r) | ((cyc == m_end) & rd_ok);
  wire data_go = (cyc == d_end) & rd_ok;

  // frame flags clear as soon as chip select rises, no serial clock needed
  always_ff @(posedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      in_frame_r <= 1'b0;
      data_act_r <= 1'b0;
      hi_r <= 1'b0;
    end else begin
      in_frame_r <= 1'b1;
      data_act_r <= data_act_r | data_go;
      hi_r <= data_go | (data_act_r & ~hi_r);
    end
  end

  // frame results hold after chip select rises, for the system side to read
  always_ff @(posedge SCLK_I) begin
    cnt_r <= cyc;
    op_r <= op_nxt;
    addr_r <= addr_nxt;
    byte_r <= byte_nxt;
    ones_r <= ones_nxt;
    mode_ok_r <= mode_ok_nxt;
  end

  // array answers the registered address; high nibble first on the falling edge
  always_ff @(negedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      DQ_O <= 4'h0;
      DQ_OE_O <= 4'h0;
    end else begin
      DQ_O <= hi_r ? ARRAY_DATA_I[7:4] : ARRAY_DATA_I[3:0];
      DQ_OE_O <= {4{data_act_r}};
    end
  end

  assign ARRAY_ADDR_O = addr_r;

  // ------------------------------------------------------------------
  // system domain
  // ------------------------------------------------------------------
  logic cs_s;
  logic hwr_s;
  logic cs_d_r;
  qrw_pkg::qrw_state_t state_r;
  qrw_pkg::qrw_state_t state_nxt;
  logic [31:0] tmr_r;
  logic [31:0] tmr_nxt;
  logic [3:0] prot_r;

  qrw_sync #(.W(2), .RST_VAL(2'b11)) u_in_sync (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RESETN_I),
    .d_i({HW_RESET_N_I, CS_N_I}),
    .q_o({hwr_s, cs_s})
  );

  wire fe = cs_s & ~cs_d_r;
  wire idle = (state_r == qrw_pkg::ST_IDLE);
  wire [6:0] f_cmd = qmode_r ? qrw_pkg::CMD_CYC_QUAD : qrw_pkg::CMD_CYC_SINGLE;
  wire [6:0] f_er = f_cmd + (qmode_r ? qrw_pkg::ER_ADDR_CYC_QUAD : qrw_pkg::ER_ADDR_CYC_SINGLE);
  wire f_se = (op_r == qrw_pkg::OP_SECTOR_ERASE);
  wire f_hbe = (op_r == qrw_pkg::OP_HALF_BLOCK_ERASE);

  // all-ones frame of the reset length, in either command mode
  wire is_ff = ones_r & ((cnt_r == qrw_pkg::FF_CYC_SINGLE) |
                         (qmode_r & (cnt_r == qrw_pkg::FF_CYC_QUAD)));
  wire toggling = (byte_r[7:4] == ~byte_r[3:0]);
  wire is_write_enable_cmd = ~cont_r & (op_r == qrw_pkg::OP_WRITE_ENABLE) & (cnt_r == f_cmd);
  wire is_bl = ~cont_r & (op_r == qrw_pkg::OP_BURST_LEN) & (cnt_r == f_cmd + f_cmd);
  wire bl_on = is_bl & (byte_r[7:4] == qrw_pkg::WRAP_ON_NIB) & (byte_r[3:2] == 2'b00);
  wire bl_off = is_bl & (byte_r[7:4] == qrw_pkg::WRAP_OFF_NIB);

  // top blocks protected: none for 0, else 2^(level-1) blocks of 64K, at most the whole array
  wire [3:0] bp_m1 = prot_r - 4'h1;
  wire [BLK_W+1:0] prot_cnt = (prot_r == 4'h0) ? '0 :
                              (bp_m1 >= 4'(BLK_W)) ? (BLK_W+2)'(1) << BLK_W :
                              (BLK_W+2)'(1) << bp_m1;
  wire [BLK_W+1:0] blk_sum = {2'b00, addr_r[ADDR_W-1:qrw_pkg::BLOCK_LSB]} + prot_cnt;
  wire prot_hit = blk_sum >= ((BLK_W+2)'(1) << BLK_W);

  // count must end exactly on the last address bit
  wire er_exact = ~cont_r & (f_se | f_hbe) & (cnt_r == f_er);
  wire er_go = fe & idle & er_exact & wel_r & hwr_s & ~prot_hit;

  wire [ADDR_W-1:0] se_addr = {addr_r[ADDR_W-1:qrw_pkg::SECTOR_LSB],
                               {qrw_pkg::SECTOR_LSB{1'b0}}};
  wire [ADDR_W-1:0] hbe_addr = {addr_r[ADDR_W-1:qrw_pkg::HALF_BLOCK_LSB],
                                {qrw_pkg::HALF_BLOCK_LSB{1'b0}}};

  wire abort = (state_r == qrw_pkg::ST_ERASE) & ~hwr_s;
  wire done = ~idle & ~abort & (tmr_r == 32'h0);

  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    case (state_r)
      qrw_pkg::ST_IDLE: begin
        if (er_go) begin
          state_nxt = qrw_pkg::ST_ERASE;
          tmr_nxt = f_se ? 32'(SE_CYC - 1) : 32'(HBE_CYC - 1);
        end
      end
      qrw_pkg::ST_ERASE: begin
        if (abort) begin
          state_nxt = qrw_pkg::ST_RECOVER;
          tmr_nxt = 32'(REC_CYC - 1);
        end else if (done) begin
          state_nxt = qrw_pkg::ST_IDLE;
        end else begin
          tmr_nxt = tmr_r - 32'h1;
        end
      end
      qrw_pkg::ST_RECOVER: begin
        if (done) begin
          state_nxt = qrw_pkg::ST_IDLE;
        end else begin
          tmr_nxt = tmr_r - 32'h1;
        end
      end
      default: begin
        state_nxt = qrw_pkg::ST_IDLE;
        tmr_nxt = 32'h0;
      end
    endcase
  end

  // continuous read: the reset pattern wins, else the mode byte decides
  wire cont_nxt = ~hwr_s ? 1'b0 :
                  ~fe ? cont_r :
                  is_ff ? 1'b0 :
                  mode_ok_r ? toggling : cont_r;
  wire wrap_en_nxt = ~hwr_s ? 1'b0 :
                     (fe & bl_on) ? 1'b1 :
                     (fe & bl_off) ? 1'b0 : wrap_en_r;
  // end of erase or recovery clears the latch; write enable only when idle
  wire wel_nxt = (~hwr_s | done) ? 1'b0 :
                 (fe & idle & is_write_enable_cmd) ? 1'b1 : wel_r;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      cs_d_r <= 1'b1;
      state_r <= qrw_pkg::ST_IDLE;
      tmr_r <= 32'h0;
      cont_r <= 1'b0;
      cont_op_r <= qrw_pkg::OP_QUAD_IO_READ;
      wrap_en_r <= 1'b0;
      wrap_depth_r <= 2'b00;
      wel_r <= 1'b0;
      wip_r <= 1'b0;
      qmode_r <= 1'b0;
      qe_r <= 1'b0;
      prot_r <= 4'h0;
    end else begin
      cs_d_r <= cs_s;
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      cont_r <= cont_nxt;
      cont_op_r <= (fe & mode_ok_r & toggling) ? op_r : cont_op_r;
      wrap_en_r <= wrap_en_nxt;
      wrap_depth_r <= (fe & bl_on & hwr_s) ? byte_r[1:0] : wrap_depth_r;
      wel_r <= wel_nxt;
      wip_r <= (state_nxt != qrw_pkg::ST_IDLE);
      qmode_r <= QUAD_MODE_I;
      qe_r <= QUAD_ENABLE_I;
      prot_r <= PROTECT_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      ERASE_START_O <= 1'b0;
      ERASE_HALF_BLOCK_O <= 1'b0;
      ERASE_ADDR_O <= '0;
      ERASE_ABORT_O <= 1'b0;
      STATUS_O <= 2'b00;
      CONT_MODE_O <= 1'b0;
      WRAP_EN_O <= 1'b0;
      WRAP_DEPTH_O <= 2'b00;
    end else begin
      ERASE_START_O <= er_go;
      ERASE_HALF_BLOCK_O <= er_go ? f_hbe : ERASE_HALF_BLOCK_O;
      ERASE_ADDR_O <= er_go ? (f_se ? se_addr : hbe_addr) : ERASE_ADDR_O;
      ERASE_ABORT_O <= abort;
      STATUS_O[qrw_pkg::STAT_WIP_BIT] <= (state_nxt != qrw_pkg::ST_IDLE);
      STATUS_O[qrw_pkg::STAT_WEL_BIT] <= wel_nxt;
      CONT_MODE_O <= cont_nxt;
      WRAP_EN_O <= wrap_en_nxt;
      WRAP_DEPTH_O <= (fe & bl_on & hwr_s) ? byte_r[1:0] : wrap_depth_r;
    end
  end
endmodule : qrw_flash_seq

// [tb/qrw_flash_seq_checker.sv]
// port level assertions for the flash command block
`timescale 1ns/1ps
module qrw_flash_seq_checker #(
  parameter int ADDR_W = 24
) (
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic CS_N_I,
  input wire logic HW_RESET_N_I,
  input wire logic [3:0] PROTECT_I,
  input wire logic [3:0] DQ_OE_O,
  input wire logic ERASE_START_O,
  input wire logic ERASE_HALF_BLOCK_O,
  input wire logic [ADDR_W-1:0] ERASE_ADDR_O,
  input wire logic ERASE_ABORT_O,
  input wire logic [1:0] STATUS_O,
  input wire logic CONT_MODE_O,
  input wire logic WRAP_EN_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESETN_I);
  property p_cs_idle; CS_N_I |-> DQ_OE_O == 4'h0; endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("lines driven while idle");
  property p_pulse; ERASE_START_O |=> !ERASE_START_O; endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_busy; ERASE_START_O |-> STATUS_O[0] && $past(STATUS_O) == 2'b10; endproperty
  a_busy: assert property (p_busy) else $error("start without latch or busy");
  property p_sector; ERASE_START_O && !ERASE_HALF_BLOCK_O |-> ERASE_ADDR_O[11:0] == 12'h000;
  endproperty
  a_sector: assert property (p_sector) else $error("sector base unaligned");
  property p_half; ERASE_START_O && ERASE_HALF_BLOCK_O |-> ERASE_ADDR_O[14:0] == 15'h0000;
  endproperty
  a_half: assert property (p_half) else $error("block base unaligned");
  property p_prot; ERASE_START_O && PROTECT_I == 4'h1 |-> ERASE_ADDR_O[ADDR_W-1 -: 8] != 8'hFF;
  endproperty
  a_prot: assert property (p_prot) else $error("protected region erased");
  property p_done; $fell(STATUS_O[0]) |-> !STATUS_O[1]; endproperty
  a_done: assert property (p_done) else $error("latch kept after erase");
  property p_abort; ERASE_ABORT_O |=> STATUS_O[0] ##1 STATUS_O[0]; endproperty
  a_abort: assert property (p_abort) else $error("no recovery after abort");
  property p_hwrst; $fell(HW_RESET_N_I) |-> ##[1:6] !(CONT_MODE_O || WRAP_EN_O || STATUS_O[1]);
  endproperty
  a_hwrst: assert property (p_hwrst) else $error("reset pin left state");
  property p_cont; $rose(CONT_MODE_O) |-> CS_N_I; endproperty
  a_cont: assert property (p_cont) else $error("cont mode set in frame");
  c_sector: cover property (ERASE_START_O && !ERASE_HALF_BLOCK_O);
  c_half: cover property (ERASE_START_O && ERASE_HALF_BLOCK_O);
  c_cont: cover property ($rose(CONT_MODE_O));
endmodule : qrw_flash_seq_checker
bind qrw_flash_seq qrw_flash_seq_checker #(.ADDR_W(ADDR_W)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .CS_N_I(CS_N_I), .HW_RESET_N_I(HW_RESET_N_I),
  .PROTECT_I(PROTECT_I), .DQ_OE_O(DQ_OE_O), .ERASE_START_O(ERASE_START_O),
  .ERASE_HALF_BLOCK_O(ERASE_HALF_BLOCK_O), .ERASE_ADDR_O(ERASE_ADDR_O),
  .ERASE_ABORT_O(ERASE_ABORT_O), .STATUS_O(STATUS_O), .CONT_MODE_O(CONT_MODE_O),
  .WRAP_EN_O(WRAP_EN_O));

// [tb/qrw_host_model.sv]
// behavioural host controller: chip select, serial clock, data lines
`timescale 1ns/1ps
module qrw_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] dq_o,
  input wire logic [3:0] line_i
);
  localparam int HALF = 40;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    dq_o = 4'h6;
  end
  // one clock: drive after falling edge, sample at rising edge
  task automatic clk(input logic [3:0] v, output logic [3:0] r);
    dq_o = v;
    #HALF sclk_o = 1'b1;
    r = line_i;
    #HALF sclk_o = 1'b0;
  endtask : clk
  task automatic opc(input logic [7:0] b, input logic q);
    logic [3:0] r;
    if (q) begin
      clk(b[7:4], r);
      clk(b[3:0], r);
    end else begin
      // upper lines toggle so a design that reads them gets garbage
      for (int i = 7; i >= 0; i--) clk({~dq_o[3:1], b[i]}, r);
    end
  endtask : opc
  // frames start 1 ns after a system falling edge, never on a sampling edge
  task automatic begin_f();
    #(HALF + 1 - ($time % 4));
    cs_n_o = 1'b0;
  endtask : begin_f
  task automatic end_f();
    #HALF cs_n_o = 1'b1;
    dq_o = ~dq_o;
    #200;
  endtask : end_f
endmodule : qrw_host_model

// [tb/tb_qrw_flash_seq.sv]
// self-checking bench for the quad read, wrap and erase command block
`timescale 1ns/1ps
module tb_qrw_flash_seq;
  logic CLK_SYS_I = 1'b0, RESETN_I = 1'b0, HW_RESET_N_I = 1'b1;
  logic QUAD_ENABLE_I = 1'b1, QUAD_MODE_I = 1'b0;
  logic [3:0] PROTECT_I = 4'h0;
  logic sclk, cs_n, ERASE_START_O, ERASE_HALF_BLOCK_O, ERASE_ABORT_O, CONT_MODE_O, WRAP_EN_O;
  logic [3:0] h_dq, line, DQ_O, DQ_OE_O;
  logic [23:0] ARRAY_ADDR_O, ERASE_ADDR_O, st_addr, a;
  logic [7:0] ARRAY_DATA_I;
  logic [1:0] STATUS_O, WRAP_DEPTH_O;
  logic st_half, oe_seen;
  logic [31:0] rng = 32'h0000005F;
  int err_total = 0, n_compared = 0, cyc = 0, n_start = 0, n_abort = 0;
  int m_wrap = 0, m_depth = 0, m_cont = 0;
  function automatic logic [7:0] memf(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h5A;
  endfunction : memf
  function automatic logic [23:0] nexta(input logic [23:0] x);
    logic [23:0] u;
    u = (24'h000008 << m_depth) - 24'h000001;
    if (m_wrap == 0) return x + 24'h000001;
    return (x & ~u) | ((x + 24'h000001) & u);
  endfunction : nexta
  function automatic logic [23:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[23:0];
  endfunction : xs
  always #2 CLK_SYS_I = ~CLK_SYS_I;
  assign line = (DQ_OE_O != 4'h0) ? DQ_O : h_dq;
  assign ARRAY_DATA_I = memf(ARRAY_ADDR_O);
  qrw_host_model h (.sclk_o(sclk), .cs_n_o(cs_n), .dq_o(h_dq), .line_i(line));
  // sector erase must outlast the refused read that follows it
  qrw_flash_seq #(.SECTOR_ERASE_TIME_US(3), .HALF_BLOCK_ERASE_TIME_US(1),
    .ERASE_RECOVERY_TIME_US(1)) uut (
    .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .SCLK_I(sclk), .CS_N_I(cs_n), .DQ_I(line),
    .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O), .HW_RESET_N_I(HW_RESET_N_I),
    .QUAD_ENABLE_I(QUAD_ENABLE_I), .QUAD_MODE_I(QUAD_MODE_I), .PROTECT_I(PROTECT_I),
    .ARRAY_ADDR_O(ARRAY_ADDR_O), .ARRAY_DATA_I(ARRAY_DATA_I), .ERASE_START_O(ERASE_START_O),
    .ERASE_HALF_BLOCK_O(ERASE_HALF_BLOCK_O), .ERASE_ADDR_O(ERASE_ADDR_O),
    .ERASE_ABORT_O(ERASE_ABORT_O), .STATUS_O(STATUS_O), .CONT_MODE_O(CONT_MODE_O),
    .WRAP_EN_O(WRAP_EN_O), .WRAP_DEPTH_O(WRAP_DEPTH_O));
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  always @(posedge sclk) if (DQ_OE_O !== 4'h0) oe_seen <= 1'b1;
  always @(posedge CLK_SYS_I) begin
    cyc++;
    if (ERASE_START_O === 1'b1) begin
      n_start++;
      st_addr = ERASE_ADDR_O;
      st_half = ERASE_HALF_BLOCK_O;
    end
    if (ERASE_ABORT_O === 1'b1) n_abort++;
    if (cyc == 60000) begin
      err_total++;
      $display("[FAIL] run length expected below 60000 seen %0d", cyc);
      close_out();
    end
  end
  task automatic setin(input logic qe, input logic qm, input logic [3:0] pr);
    @(negedge CLK_SYS_I);
    QUAD_ENABLE_I = qe;
    QUAD_MODE_I = qm;
    PROTECT_I = pr;
  endtask : setin
  task automatic rd(input logic q, input logic [7:0] op, input logic [23:0] x,
    input logic [7:0] m, input int n, input logic ok);
    logic [3:0] r, hi;
    logic [23:0] ea;
    ea = x;
    oe_seen = 1'b0;
    h.begin_f();
    if (m_cont == 0) h.opc(op, q);
    for (int i = 5; i >= 0; i--) h.clk(x[i*4 +: 4], r);
    h.opc(m, 1'b1);
    repeat (op == 8'hE7 ? 2 : 4) h.clk(~h_dq, r);
    for (int i = 0; i < n; i++) begin
      h.clk(~h_dq, hi);
      h.clk(~h_dq, r);
      if (ok) chk("read byte", memf(ea), {hi, r});
      ea = nexta(ea);
    end
    h.end_f();
    if (ok) m_cont = (m[7:4] == ~m[3:0]) ? 1 : 0;
    chk("cont mode", m_cont, CONT_MODE_O);
    if (!ok) chk("refused lines", 0, oe_seen);
  endtask : rd
  task automatic frm(input logic q, input logic [7:0] op, input logic [7:0] b, input int nb);
    logic [3:0] r;
    h.begin_f();
    h.opc(op, q);
    if (q && nb > 0) for (int i = 5; i >= 0; i--) h.clk(a[i*4 +: 4], r);
    else for (int i = 23; i > 23 - nb; i--) h.clk({~h_dq[3:1], a[i]}, r);
    if (nb < 0) h.opc(b, q);
    h.end_f();
  endtask : frm
  task automatic wait_idle();
    for (int i = 0; i < 1000 && STATUS_O !== 2'b00; i++) @(negedge CLK_SYS_I);
    chk("idle status", 0, STATUS_O);
  endtask : wait_idle
  initial begin
    repeat (4) @(negedge CLK_SYS_I);
    RESETN_I = 1'b1;
    repeat (8) @(negedge CLK_SYS_I);
    chk("status", 0, STATUS_O);
    chk("wrap", 0, WRAP_EN_O);
    rd(1'b0, 8'hEB, 24'hFFFFFE, 8'h00, 4, 1'b1);
    $display("test rollover done");
    for (int d = 0; d < 4; d++) begin
      setin(1'b1, d[0], 4'h0);
      frm(d[0], 8'hC0, {4'h0, 4'(d)}, -1);
      m_wrap = 1;
      m_depth = d;
      chk("wrap depth", {1'b1, 2'(d)}, {WRAP_EN_O, WRAP_DEPTH_O});
      rd(d[0], d == 2 ? 8'hE7 : (d == 3 ? 8'h0B : 8'hEB), xs(), 8'hFF, (8 << d) + 2, 1'b1);
    end
    frm(1'b1, 8'hC0, 8'h1F, -1);
    m_wrap = 0;
    chk("wrap off", 0, WRAP_EN_O);
    $display("test wrap done");
    rd(1'b1, 8'hEB, xs(), 8'hA5, 2, 1'b1);
    rd(1'b1, 8'hEB, xs(), 8'h5A, 2, 1'b1);
    frm(1'b1, 8'hFF, 8'h00, 0);
    m_cont = 0;
    chk("cont reset", 0, CONT_MODE_O);
    setin(1'b1, 1'b0, 4'h0);
    rd(1'b0, 8'hE7, xs(), 8'h0F, 2, 1'b1);
    rd(1'b0, 8'hE7, xs(), 8'h55, 2, 1'b1);
    setin(1'b0, 1'b0, 4'h0);
    rd(1'b0, 8'hEB, xs(), 8'hA5, 2, 1'b0);
    setin(1'b1, 1'b1, 4'h0);
    rd(1'b1, 8'hE7, xs(), 8'hA5, 2, 1'b0);
    $display("test continuous read done");
    setin(1'b1, 1'b0, 4'h1);
    frm(1'b0, 8'h06, 8'h00, 0);
    a = 24'hFF1234;
    frm(1'b0, 8'h20, 8'h00, 24);
    chk("protected", 0, n_start);
    chk("latch kept", 2, STATUS_O);
    a = xs() & 24'h7FFFFF;
    frm(1'b0, 8'h20, 8'h00, 24);
    chk("sector base", {1'b0, a & 24'hFFF000}, {st_half, st_addr});
    chk("busy", 3, STATUS_O);
    rd(1'b0, 8'hEB, a, 8'h00, 2, 1'b0);
    wait_idle();
    frm(1'b0, 8'h20, 8'h00, 24);
    frm(1'b0, 8'h06, 8'h00, 0);
    frm(1'b0, 8'h20, 8'h00, 23);
    chk("dropped erases", 1, n_start);
    setin(1'b1, 1'b1, 4'h1);
    frm(1'b1, 8'h52, 8'h00, 6);
    chk("block base", {1'b1, a & 24'hFF8000}, {st_half, st_addr});
    @(negedge CLK_SYS_I);
    HW_RESET_N_I = 1'b0;
    repeat (4) @(negedge CLK_SYS_I);
    HW_RESET_N_I = 1'b1;
    chk("abort", 1, n_abort != 0);
    chk("recovery busy", 1, STATUS_O[0]);
    wait_idle();
    $display("test erase done");
    close_out();
  end
endmodule : tb_qrw_flash_seq
